// *** ppc_pkg.sv ***
// shared constants, types and helpers for the port pin configuration block
package ppc_pkg;

  localparam int unsigned addr_w = 12;
  localparam int unsigned idx_w = 10;

  // register indexes; the byte address is four times the index
  localparam logic [9:0] idx_addr_a_data = 10'h000;
  localparam logic [9:0] idx_addr_b_data = 10'h001;
  localparam logic [9:0] idx_addr_a_dir = 10'h002;
  localparam logic [9:0] idx_addr_b_dir = 10'h003;
  localparam logic [9:0] idx_mode_data = 10'h008;
  localparam logic [9:0] idx_mode_dir = 10'h009;
  localparam logic [9:0] idx_pull = 10'h00c;
  localparam logic [9:0] idx_drive = 10'h00d;
  localparam logic [9:0] idx_pulse_dir = 10'h057;
  localparam logic [9:0] idx_timer_dir = 10'h0af;
  localparam logic [9:0] idx_serial_dir = 10'h0d7;
  localparam logic [9:0] idx_interic_dir = 10'h0e7;
  localparam logic [9:0] idx_page_dir = 10'h0fd;
  localparam logic [9:0] idx_periph_pd = 10'h100;

  // bit positions in the pull and drive control registers
  localparam int unsigned bit_addr_a = 0;
  localparam int unsigned bit_addr_b = 1;
  localparam int unsigned bit_mode = 4;
  localparam int unsigned bit_wake_h = 5;
  localparam int unsigned bit_wake_j = 6;
  localparam int unsigned bit_page = 7;

  // bit positions in the peripheral pull/drive register
  localparam int unsigned bit_pulse_pull = 0;
  localparam int unsigned bit_pulse_drive = 1;
  localparam int unsigned bit_serial_pull = 2;
  localparam int unsigned bit_serial_drive = 3;
  localparam int unsigned bit_timer_pull = 4;
  localparam int unsigned bit_timer_drive = 5;
  localparam int unsigned bit_interic_pull = 6;
  localparam int unsigned bit_interic_drive = 7;

  // writable bits and pin masks
  localparam logic [7:0] ctl_mask = 8'hf3;
  localparam logic [7:0] all_pins = 8'hff;
  localparam logic [7:0] mode_oe_mask = 8'hfc;
  localparam logic [7:0] mode_pull_mask = 8'h8f;
  localparam logic [7:0] page_mask = 8'h8f;
  localparam logic [7:0] pulse_mask = 8'h0f;
  localparam logic [7:0] interic_mask = 8'hc0;

  // reset values and fixed pin control values
  localparam logic [7:0] dir_reset = 8'h00;
  localparam logic [7:0] data_reset = 8'h00;
  localparam logic [7:0] pull_reset = 8'h10;
  localparam logic [7:0] drive_reset = 8'h00;
  localparam logic [7:0] periph_pd_reset = 8'h04;
  localparam logic [2:0] can_pull_on = 3'h7;
  localparam logic [15:0] analog_ctl_off = 16'h0000;

  typedef enum logic [1:0] {
    drv_open = 2'b00,
    drv_locked = 2'b01
  } ppc_drv_state_type;

  typedef enum logic [3:0] {
    sel_none, sel_a_data, sel_b_data, sel_a_dir, sel_b_dir, sel_mode_data, sel_mode_dir,
    sel_pull, sel_drive, sel_pulse_dir, sel_timer_dir, sel_serial_dir, sel_interic_dir,
    sel_page_dir, sel_periph_pd
  } ppc_sel_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ppc_apb_req_type;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull;
    logic [7:0] low_drive;
  } ppc_pin_ctl_type;

  typedef struct packed {
    logic [7:0] en;
    logic [7:0] out;
    logic [7:0] oe;
  } ppc_periph_type;

  typedef struct packed {
    logic [7:0] page;
    logic [7:0] pulse;
    logic [7:0] serial;
    logic [7:0] timer;
    logic [7:0] interic;
  } ppc_gpio_data_type;

  typedef struct packed {
    logic [7:0] addr_a;
    logic [7:0] addr_b;
    logic [7:0] mode;
  } ppc_pin_in_type;

  typedef struct packed {
    logic [2:0] tx_out;
    logic [2:0] tx_oe;
    logic [2:0] rx_pull;
  } ppc_can_pin_type;

  // register address decode; bus modes drop the address/data port registers
  function automatic ppc_sel_type ppc_decode(input logic [9:0] idx, input logic bus_mode);
    ppc_sel_type sel;
    sel = sel_none;
    case (idx)
      idx_addr_a_data: sel = bus_mode ? sel_none : sel_a_data;
      idx_addr_b_data: sel = bus_mode ? sel_none : sel_b_data;
      idx_addr_a_dir: sel = bus_mode ? sel_none : sel_a_dir;
      idx_addr_b_dir: sel = bus_mode ? sel_none : sel_b_dir;
      idx_mode_data: sel = sel_mode_data;
      idx_mode_dir: sel = sel_mode_dir;
      idx_pull: sel = sel_pull;
      idx_drive: sel = sel_drive;
      idx_pulse_dir: sel = sel_pulse_dir;
      idx_timer_dir: sel = sel_timer_dir;
      idx_serial_dir: sel = sel_serial_dir;
      idx_interic_dir: sel = sel_interic_dir;
      idx_page_dir: sel = sel_page_dir;
      idx_periph_pd: sel = sel_periph_pd;
      default: sel = sel_none;
    endcase
    return sel;
  endfunction

  // outputs read back their latch, inputs read the pin
  function automatic logic [7:0] ppc_port_read(input logic [7:0] latch, input logic [7:0] dir,
                                               input logic [7:0] pin);
    return (latch & dir) | (pin & ~dir);
  endfunction

endpackage

// *** ppc_apb_slave.sv ***
// apb slave front end: strobes, ready and error answer
`timescale 1ns/1ps
module ppc_apb_slave
  import ppc_pkg::*;
(
  input wire ppc_apb_req_type i_apb,
  input wire logic i_hit,
  output logic [9:0] o_index,
  output logic o_wr,
  output logic o_rd_setup,
  output logic o_pready,
  output logic o_pslverr
);

  assign o_index = i_apb.paddr[11:2];
  // read data is captured in the setup cycle so the access phase needs no wait
  assign o_rd_setup = i_apb.psel & ~i_apb.penable & ~i_apb.pwrite;
  assign o_wr = i_apb.psel & i_apb.penable & i_apb.pwrite & i_hit;
  assign o_pready = i_apb.psel & i_apb.penable;
  assign o_pslverr = i_apb.psel & i_apb.penable & ~i_hit;

endmodule

// *** ppc_pin_mux.sv ***
// one 8-pin port: peripheral takeover, direction, pull and drive shaping
`timescale 1ns/1ps
module ppc_pin_mux
  import ppc_pkg::*;
(
  input wire logic [7:0] i_dir,
  input wire logic [7:0] i_data,
  input wire ppc_periph_type i_periph,
  input wire logic i_pull_en,
  input wire logic i_low_drive,
  input wire logic [7:0] i_oe_mask,
  input wire logic [7:0] i_pull_mask,
  input wire logic [7:0] i_drive_mask,
  output ppc_pin_ctl_type o_pin
);

  logic [7:0] oe;

  assign oe = i_oe_mask & ((i_periph.en & i_periph.oe) | (~i_periph.en & i_dir));
  assign o_pin.out = (i_periph.en & i_periph.out) | (~i_periph.en & i_data);
  assign o_pin.oe = oe;
  // pull only on pins that are inputs now
  assign o_pin.pull = i_pull_mask & ~oe & {8{i_pull_en}};
  assign o_pin.low_drive = i_drive_mask & {8{i_low_drive}};

endmodule

// *** ppc_port_config.sv ***
// port pin configuration: register file, pin muxing, pull and drive controls
`timescale 1ns/1ps
module ppc_port_config
  import ppc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire ppc_apb_req_type i_apb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_expanded,
  input wire logic i_peripheral,
  input wire ppc_pin_in_type i_pin_in,
  input wire ppc_gpio_data_type i_gpio_data,
  input wire ppc_periph_type i_bus_a,
  input wire ppc_periph_type i_bus_b,
  input wire ppc_periph_type i_bus_mode_port,
  input wire ppc_periph_type i_page_emul,
  input wire ppc_periph_type i_pwm,
  input wire ppc_periph_type i_serial,
  input wire ppc_periph_type i_timer,
  input wire ppc_periph_type i_interic,
  input wire logic [2:0] i_can_tx,
  output ppc_pin_ctl_type o_pin_addr_a,
  output ppc_pin_ctl_type o_pin_addr_b,
  output ppc_pin_ctl_type o_pin_mode,
  output ppc_pin_ctl_type o_pin_page,
  output ppc_pin_ctl_type o_pin_pulse,
  output ppc_pin_ctl_type o_pin_serial,
  output ppc_pin_ctl_type o_pin_timer,
  output ppc_pin_ctl_type o_pin_interic,
  output ppc_can_pin_type o_can,
  output logic [1:0] o_wake_pull,
  output logic [1:0] o_wake_low_drive,
  output logic [15:0] o_analog_ctl
);

  typedef struct packed {
    logic [7:0] addr_a_data;
    logic [7:0] addr_b_data;
    logic [7:0] addr_a_dir;
    logic [7:0] addr_b_dir;
    logic [7:0] mode_data;
    logic [7:0] mode_dir;
    logic [7:0] pull;
    logic [7:0] drive;
    logic [7:0] pulse_dir;
    logic [7:0] timer_dir;
    logic [7:0] serial_dir;
    logic [7:0] interic_dir;
    logic [7:0] page_dir;
    logic [7:0] periph_pd;
    ppc_drv_state_type drive_state;
    logic [31:0] rdata;
  } ppc_state_type;

  ppc_state_type state;
  ppc_state_type next_state;
  logic bus_mode;
  logic [9:0] index;
  ppc_sel_type sel;
  logic hit;
  logic wr;
  logic rd_setup;
  logic [7:0] wdata;
  logic [7:0] rvalue;
  ppc_periph_type bus_a_take;
  ppc_periph_type bus_b_take;
  ppc_periph_type page_take;
  ppc_periph_type interic_take;
  ppc_periph_type pulse_take;

  assign bus_mode = i_expanded | i_peripheral;
  assign wdata = i_apb.pwdata[7:0];

  ppc_apb_slave u_apb (
    .i_apb(i_apb),
    .i_hit(hit),
    .o_index(index),
    .o_wr(wr),
    .o_rd_setup(rd_setup),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr)
  );

  // removed registers decode as unmapped
  assign sel = ppc_decode(index, bus_mode);
  assign hit = (sel != sel_none);

  // read value of the selected register
  always_comb begin
    rvalue = 8'h00;
    case (sel)
      sel_a_data: begin
        rvalue = ppc_port_read(state.addr_a_data, state.addr_a_dir, i_pin_in.addr_a);
      end
      sel_b_data: begin
        rvalue = ppc_port_read(state.addr_b_data, state.addr_b_dir, i_pin_in.addr_b);
      end
      sel_a_dir: begin
        rvalue = state.addr_a_dir;
      end
      sel_b_dir: begin
        rvalue = state.addr_b_dir;
      end
      sel_mode_data: begin
        rvalue = ppc_port_read(state.mode_data, state.mode_dir, i_pin_in.mode);
      end
      sel_mode_dir: begin
        rvalue = state.mode_dir;
      end
      sel_pull: begin
        rvalue = state.pull;
      end
      sel_drive: begin
        rvalue = state.drive;
      end
      sel_pulse_dir: begin
        rvalue = state.pulse_dir;
      end
      sel_timer_dir: begin
        rvalue = state.timer_dir;
      end
      sel_serial_dir: begin
        rvalue = state.serial_dir;
      end
      sel_interic_dir: begin
        rvalue = state.interic_dir;
      end
      sel_page_dir: begin
        rvalue = state.page_dir;
      end
      sel_periph_pd: begin
        rvalue = state.periph_pd;
      end
      default: begin
        rvalue = 8'h00;
      end
    endcase
  end

  // register updates
  always_comb begin
    next_state = state;
    if (rd_setup) begin
      next_state.rdata = {24'h000000, rvalue};
    end
    if (wr) begin
      case (sel)
        sel_a_data: begin
          next_state.addr_a_data = wdata;
        end
        sel_b_data: begin
          next_state.addr_b_data = wdata;
        end
        sel_a_dir: begin
          next_state.addr_a_dir = wdata;
        end
        sel_b_dir: begin
          next_state.addr_b_dir = wdata;
        end
        sel_mode_data: begin
          next_state.mode_data = wdata;
        end
        sel_mode_dir: begin
          next_state.mode_dir = wdata & mode_oe_mask;
        end
        sel_pull: begin
          next_state.pull = wdata & ctl_mask;
        end
        sel_drive: begin
          case (state.drive_state)
            drv_open: begin
              next_state.drive = wdata & ctl_mask;
              next_state.drive_state = drv_locked;
            end
            default: begin
              next_state.drive = state.drive;
            end
          endcase
        end
        sel_pulse_dir: begin
          next_state.pulse_dir = wdata & pulse_mask;
        end
        sel_timer_dir: begin
          next_state.timer_dir = wdata;
        end
        sel_serial_dir: begin
          next_state.serial_dir = wdata;
        end
        sel_interic_dir: begin
          next_state.interic_dir = wdata & interic_mask;
        end
        sel_page_dir: begin
          next_state.page_dir = wdata & page_mask;
        end
        sel_periph_pd: begin
          next_state.periph_pd = wdata;
        end
        default: begin
          next_state.rdata = state.rdata;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state.addr_a_data <= data_reset;
      state.addr_b_data <= data_reset;
      state.addr_a_dir <= dir_reset;
      state.addr_b_dir <= dir_reset;
      state.mode_data <= data_reset;
      state.mode_dir <= dir_reset;
      state.pull <= pull_reset;
      state.drive <= drive_reset;
      state.pulse_dir <= dir_reset;
      state.timer_dir <= dir_reset;
      state.serial_dir <= dir_reset;
      state.interic_dir <= dir_reset;
      state.page_dir <= dir_reset;
      state.periph_pd <= periph_pd_reset;
      state.drive_state <= drv_open;
      state.rdata <= 32'h00000000;
    end else begin
      state <= next_state;
    end
  end

  assign o_prdata = state.rdata;

  // bus modes hand the address/data and page pins to the bus
  assign bus_a_take.en = {8{bus_mode}};
  assign bus_a_take.out = i_bus_a.out;
  assign bus_a_take.oe = i_bus_a.oe;
  assign bus_b_take.en = {8{bus_mode}};
  assign bus_b_take.out = i_bus_b.out;
  assign bus_b_take.oe = i_bus_b.oe;
  assign page_take.en = {8{bus_mode}};
  assign page_take.out = i_page_emul.out;
  assign page_take.oe = i_page_emul.oe;
  assign interic_take.en = i_interic.en & interic_mask;
  assign interic_take.out = i_interic.out;
  assign interic_take.oe = i_interic.oe;
  assign pulse_take.en = i_pwm.en & pulse_mask;
  assign pulse_take.out = i_pwm.out;
  assign pulse_take.oe = i_pwm.oe;

  ppc_pin_mux u_addr_a (
    .i_dir(state.addr_a_dir),
    .i_data(state.addr_a_data),
    .i_periph(bus_a_take),
    .i_pull_en(state.pull[bit_addr_a]),
    .i_low_drive(state.drive[bit_addr_a]),
    .i_oe_mask(all_pins),
    .i_pull_mask(all_pins),
    .i_drive_mask(all_pins),
    .o_pin(o_pin_addr_a)
  );

  ppc_pin_mux u_addr_b (
    .i_dir(state.addr_b_dir),
    .i_data(state.addr_b_data),
    .i_periph(bus_b_take),
    .i_pull_en(state.pull[bit_addr_b]),
    .i_low_drive(state.drive[bit_addr_b]),
    .i_oe_mask(all_pins),
    .i_pull_mask(all_pins),
    .i_drive_mask(all_pins),
    .o_pin(o_pin_addr_b)
  );

  // bits 1:0 never drive, bits 6:4 have no pull
  ppc_pin_mux u_mode (
    .i_dir(state.mode_dir),
    .i_data(state.mode_data),
    .i_periph(i_bus_mode_port),
    .i_pull_en(state.pull[bit_mode]),
    .i_low_drive(state.drive[bit_mode]),
    .i_oe_mask(mode_oe_mask),
    .i_pull_mask(mode_pull_mask),
    .i_drive_mask(mode_oe_mask),
    .o_pin(o_pin_mode)
  );

  ppc_pin_mux u_page (
    .i_dir(state.page_dir),
    .i_data(i_gpio_data.page),
    .i_periph(page_take),
    .i_pull_en(state.pull[bit_page]),
    .i_low_drive(state.drive[bit_page]),
    .i_oe_mask(page_mask),
    .i_pull_mask(page_mask),
    .i_drive_mask(page_mask),
    .o_pin(o_pin_page)
  );

  ppc_pin_mux u_pulse (
    .i_dir(state.pulse_dir),
    .i_data(i_gpio_data.pulse),
    .i_periph(pulse_take),
    .i_pull_en(state.periph_pd[bit_pulse_pull]),
    .i_low_drive(state.periph_pd[bit_pulse_drive]),
    .i_oe_mask(pulse_mask),
    .i_pull_mask(pulse_mask),
    .i_drive_mask(pulse_mask),
    .o_pin(o_pin_pulse)
  );

  ppc_pin_mux u_serial (
    .i_dir(state.serial_dir),
    .i_data(i_gpio_data.serial),
    .i_periph(i_serial),
    .i_pull_en(state.periph_pd[bit_serial_pull]),
    .i_low_drive(state.periph_pd[bit_serial_drive]),
    .i_oe_mask(all_pins),
    .i_pull_mask(all_pins),
    .i_drive_mask(all_pins),
    .o_pin(o_pin_serial)
  );

  ppc_pin_mux u_timer (
    .i_dir(state.timer_dir),
    .i_data(i_gpio_data.timer),
    .i_periph(i_timer),
    .i_pull_en(state.periph_pd[bit_timer_pull]),
    .i_low_drive(state.periph_pd[bit_timer_drive]),
    .i_oe_mask(all_pins),
    .i_pull_mask(all_pins),
    .i_drive_mask(all_pins),
    .o_pin(o_pin_timer)
  );

  ppc_pin_mux u_interic (
    .i_dir(state.interic_dir),
    .i_data(i_gpio_data.interic),
    .i_periph(interic_take),
    .i_pull_en(state.periph_pd[bit_interic_pull]),
    .i_low_drive(state.periph_pd[bit_interic_drive]),
    .i_oe_mask(interic_mask),
    .i_pull_mask(interic_mask),
    .i_drive_mask(interic_mask),
    .o_pin(o_pin_interic)
  );

  // network pins belong to their modules only
  assign o_can.tx_out = i_can_tx;
  assign o_can.tx_oe = can_pull_on;
  assign o_can.rx_pull = can_pull_on;

  // key-wakeup ports keep their data logic elsewhere
  assign o_wake_pull = {state.pull[bit_wake_j], state.pull[bit_wake_h]};
  assign o_wake_low_drive = {state.drive[bit_wake_j], state.drive[bit_wake_h]};

  // analog pins: never driven, no load, no drive select
  assign o_analog_ctl = analog_ctl_off;

endmodule

// *** ppc_checker.sv ***
// concurrent checks on the port pin configuration top ports
`timescale 1ns/1ps
module ppc_checker
  import ppc_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire ppc_apb_req_type i_apb,
  input wire logic o_pslverr,
  input wire logic i_expanded,
  input wire logic i_peripheral,
  input wire ppc_periph_type i_page_emul,
  input wire ppc_periph_type i_pwm,
  input wire ppc_periph_type i_serial,
  input wire ppc_periph_type i_interic,
  input wire logic [2:0] i_can_tx,
  input wire ppc_pin_ctl_type o_pin_mode,
  input wire ppc_pin_ctl_type o_pin_page,
  input wire ppc_pin_ctl_type o_pin_pulse,
  input wire ppc_pin_ctl_type o_pin_serial,
  input wire ppc_pin_ctl_type o_pin_interic,
  input wire ppc_can_pin_type o_can,
  input wire logic [1:0] o_wake_pull,
  input wire logic [1:0] o_wake_low_drive,
  input wire logic [15:0] o_analog_ctl
);
  logic locked;
  wire logic acc = i_apb.psel & i_apb.penable;
  wire logic [9:0] idx = i_apb.paddr[11:2];
  // set by the first completed drive register write
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) locked <= 1'b0;
    else if (acc && i_apb.pwrite && idx == idx_drive) locked <= 1'b1;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  sequence s_wr(logic [9:0] ix);
    acc && i_apb.pwrite && idx == ix;
  endsequence
  chk_addr_gone: assert property (acc && (i_expanded || i_peripheral) && idx <= 10'h003 |-> o_pslverr)
    else $error("address/data register mapped in bus mode");
  chk_can_fixed: assert property (o_can.tx_oe == 3'h7 && o_can.rx_pull == 3'h7 && o_can.tx_out == i_can_tx)
    else $error("network pins not fixed");
  chk_analog_none: assert property (o_analog_ctl == 16'h0000)
    else $error("analog pins have control");
  chk_mode_input: assert property (o_pin_mode.oe[1:0] == 2'b00 && o_pin_mode.low_drive[1:0] == 2'b00)
    else $error("mode port low pins driven");
  chk_pull_inputs: assert property (((o_pin_serial.pull & o_pin_serial.oe) | (o_pin_mode.pull & o_pin_mode.oe)) == 8'h00)
    else $error("pull on an output pin");
  chk_drive_once: assert property (s_wr(idx_drive) ##0 locked |=> $stable(o_wake_low_drive))
    else $error("drive register took a second write");
  chk_pull_write: assert property (s_wr(idx_pull) |=> o_wake_pull == $past(i_apb.pwdata[6:5]))
    else $error("pull write not applied");
  chk_dir_serial: assert property (s_wr(idx_serial_dir) |=>
    ((o_pin_serial.oe ^ $past(i_apb.pwdata[7:0])) & ~i_serial.en) == 8'h00)
    else $error("serial direction not applied");
  chk_pulse_take: assert property (((o_pin_pulse.oe ^ i_pwm.oe) & i_pwm.en & pulse_mask) == 8'h00)
    else $error("modulator does not own pulse pins");
  chk_interic_take: assert property (((o_pin_interic.oe ^ i_interic.oe) & i_interic.en & interic_mask) == 8'h00)
    else $error("inter-ic module does not own pins");
  chk_page_bus: assert property ((i_expanded || i_peripheral) |-> ((o_pin_page.oe ^ i_page_emul.oe) & page_mask) == 8'h00)
    else $error("page port not owned in bus mode");
endmodule

// *** ppc_pin_partner.sv ***
// far-side model: pin levels fed back to the block's data readback
`timescale 1ns/1ps
module ppc_pin_partner
  import ppc_pkg::*;
(
  input wire logic i_clock,
  input wire ppc_pin_ctl_type i_a,
  input wire ppc_pin_ctl_type i_b,
  input wire ppc_pin_ctl_type i_m,
  input wire ppc_pin_in_type i_ext_val,
  input wire ppc_pin_in_type i_ext_on,
  output ppc_pin_in_type o_level
);
  logic [7:0] tog = 8'h5a;
  always_ff @(posedge i_clock) tog <= ~tog;
  // undriven pins without pull wander so a stale level never passes
  function automatic logic [7:0] lvl(input ppc_pin_ctl_type c, input logic [7:0] v, input logic [7:0] on,
                                     input logic [7:0] t);
    return (c.oe & c.out) | (~c.oe & on & v) | (~c.oe & ~on & (c.pull | t));
  endfunction
  assign o_level.addr_a = lvl(i_a, i_ext_val.addr_a, i_ext_on.addr_a, tog);
  assign o_level.addr_b = lvl(i_b, i_ext_val.addr_b, i_ext_on.addr_b, tog);
  assign o_level.mode = lvl(i_m, i_ext_val.mode, i_ext_on.mode, tog);
endmodule

// *** tb_ppc_port_config.sv ***
// self-checking bench for the port pin configuration block
`timescale 1ns/1ps
module tb_ppc_port_config;
  import ppc_pkg::*;
  logic i_clock, i_rstn, i_expanded, i_peripheral, o_pready, o_pslverr, rd_err;
  logic [2:0] i_can_tx;
  logic [1:0] o_wake_pull, o_wake_low_drive;
  logic [15:0] o_analog_ctl;
  logic [31:0] o_prdata;
  logic [7:0] rd_val;
  int error_cnt, n_checks;
  ppc_apb_req_type i_apb;
  ppc_gpio_data_type i_gpio_data;
  ppc_periph_type i_bus_a, i_bus_b, i_bus_mode_port, i_page_emul, i_pwm, i_serial, i_timer, i_interic;
  ppc_pin_in_type pin_lvl, ext_val, ext_on;
  ppc_pin_ctl_type o_pin_addr_a, o_pin_addr_b, o_pin_mode, o_pin_page, o_pin_pulse, o_pin_serial;
  ppc_pin_ctl_type o_pin_timer, o_pin_interic;
  ppc_can_pin_type o_can;
  ppc_port_config dut (.i_clock, .i_rstn, .i_apb, .o_prdata, .o_pready, .o_pslverr, .i_expanded, .i_peripheral,
    .i_pin_in(pin_lvl), .i_gpio_data, .i_bus_a, .i_bus_b, .i_bus_mode_port, .i_page_emul, .i_pwm, .i_serial,
    .i_timer, .i_interic, .i_can_tx, .o_pin_addr_a, .o_pin_addr_b, .o_pin_mode, .o_pin_page, .o_pin_pulse,
    .o_pin_serial, .o_pin_timer, .o_pin_interic, .o_can, .o_wake_pull, .o_wake_low_drive, .o_analog_ctl);
  ppc_pin_partner far (.i_clock, .i_a(o_pin_addr_a), .i_b(o_pin_addr_b), .i_m(o_pin_mode), .i_ext_val(ext_val),
    .i_ext_on(ext_on), .o_level(pin_lvl));
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    if (error_cnt == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    i_apb <= '{1'b1, 1'b0, w, {idx, 2'b00}, {24'h0, d}};
    @(posedge i_clock);
    i_apb.penable <= 1'b1;
    // wait for ready; a hang is ended by the watchdog only
    do begin
      @(posedge i_clock);
    end while (o_pready !== 1'b1);
    rd_val = o_prdata[7:0];
    rd_err = o_pslverr;
    i_apb.psel <= 1'b0;
    i_apb.penable <= 1'b0;
    @(posedge i_clock);
  endtask
  task rd_chk(input logic [9:0] idx, input logic [7:0] exp, input logic err);
    apb(1'b0, idx, 8'h00);
    chk({rd_err, rd_val}, {err, exp});
  endtask
  task t_reset;
    rd_chk(idx_pull, 8'h10, 1'b0);
    rd_chk(idx_drive, 8'h00, 1'b0);
    rd_chk(idx_periph_pd, 8'h04, 1'b0);
    rd_chk(idx_serial_dir, 8'h00, 1'b0);
    chk(o_pin_mode.pull, 8'h8f);
    chk(o_pin_serial.pull, 8'hff);
    chk(o_can, 9'h17f);
    chk(o_analog_ctl, 16'h0000);
  endtask
  task t_dirs;
    logic [9:0] ix [7] = '{idx_addr_b_dir, idx_mode_dir, idx_pulse_dir, idx_serial_dir, idx_interic_dir,
                           idx_page_dir, idx_timer_dir};
    logic [7:0] mk [7] = '{8'hff, 8'hfc, 8'h0f, 8'hff, 8'hc0, 8'h8f, 8'hff};
    for (int k = 0; k < 7; k++) begin
      apb(1'b1, ix[k], 8'hff);
      rd_chk(ix[k], mk[k], 1'b0);
    end
    chk(o_pin_serial.pull, 8'h00);
    chk(o_pin_mode.pull, 8'h03);
    apb(1'b1, idx_mode_data, 8'h00);
    rd_chk(idx_mode_data, 8'h03, 1'b0);
    chk(o_pin_pulse.out & 8'h0f, 8'h0a);
    apb(1'b1, idx_serial_dir, 8'h0f);
    chk(o_pin_serial.pull, 8'hf0);
    apb(1'b1, 10'h004, 8'hff);
    rd_chk(10'h004, 8'h00, 1'b1);
  endtask
  task t_data;
    apb(1'b1, idx_addr_a_dir, 8'hf0);
    apb(1'b1, idx_addr_a_data, 8'h5a);
    ext_val.addr_a <= 8'h3c;
    ext_on.addr_a <= 8'h0f;
    rd_chk(idx_addr_a_data, 8'h5c, 1'b0);
    chk(o_pin_addr_a.out & 8'hf0, 8'h50);
    apb(1'b1, idx_addr_b_data, 8'ha5);
    rd_chk(idx_addr_b_data, 8'ha5, 1'b0);
  endtask
  task t_bus;
    for (int m = 0; m < 2; m++) begin
      i_expanded <= (m == 0);
      i_peripheral <= (m == 1);
      i_bus_a <= '{8'h00, 8'h96, 8'h0f};
      i_bus_b <= '{8'h00, 8'h69, 8'hf0};
      i_page_emul <= '{8'h00, 8'h81, 8'h8f};
      for (int k = 0; k < 4; k++) begin
        apb(1'b1, 10'(k), 8'h00);
        chk(rd_err, 1'b1);
        rd_chk(10'(k), 8'h00, 1'b1);
      end
      chk({o_pin_addr_a.oe, o_pin_addr_b.oe}, 16'h0ff0);
      chk(o_pin_page.oe & page_mask, 8'h8f);
    end
    i_expanded <= 1'b0;
    i_peripheral <= 1'b0;
    @(posedge i_clock);
    rd_chk(idx_addr_a_dir, 8'hf0, 1'b0);
    rd_chk(idx_addr_a_data, 8'h5c, 1'b0);
  endtask
  task t_drive;
    apb(1'b1, idx_drive, 8'h73);
    chk({o_wake_low_drive, o_pin_mode.low_drive}, 10'h3fc);
    apb(1'b1, idx_drive, 8'h00);
    rd_chk(idx_drive, 8'h73, 1'b0);
    chk(o_wake_low_drive, 2'b11);
    apb(1'b1, idx_pull, 8'hff);
    rd_chk(idx_pull, 8'hf3, 1'b0);
    chk(o_wake_pull, 2'b11);
    apb(1'b1, idx_periph_pd, 8'h00);
    rd_chk(idx_periph_pd, 8'h00, 1'b0);
    chk(o_pin_serial.pull, 8'h00);
  endtask
  task t_periph;
    i_pwm <= '{8'h0f, 8'h05, 8'h03};
    i_interic <= '{8'hc0, 8'h40, 8'h80};
    i_timer <= '{8'hff, 8'h3c, 8'h0f};
    i_serial <= '{8'hff, 8'h99, 8'hf0};
    i_bus_mode_port <= '{8'hff, 8'hc3, 8'hff};
    repeat (2) @(posedge i_clock);
    chk({o_pin_mode.oe, o_pin_mode.out}, 16'hfcc3);
    chk({o_pin_pulse.oe[3:0], o_pin_pulse.out[3:0]}, 8'h35);
    chk({o_pin_interic.oe[7:6], o_pin_interic.out[7:6]}, 4'h9);
    chk({o_pin_timer.oe, o_pin_timer.out}, 16'h0f3c);
    chk({o_pin_serial.oe, o_pin_serial.out}, 16'hf099);
  endtask
  initial begin
    #400000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    i_rstn = 1'b0;
    i_apb = '0;
    {i_expanded, i_peripheral} = 2'b00;
    {i_bus_a, i_bus_b, i_bus_mode_port, i_page_emul, i_pwm, i_serial, i_timer, i_interic} = '0;
    i_gpio_data = {5{8'h0a}};
    i_can_tx = 3'h5;
    ext_val = '0;
    ext_on = '0;
    error_cnt = 0;
    n_checks = 0;
    repeat (3) @(posedge i_clock);
    i_rstn <= 1'b1;
    @(posedge i_clock);
    t_reset();
    t_dirs();
    t_data();
    t_bus();
    t_drive();
    t_periph();
    i_rstn <= 1'b0;
    @(posedge i_clock);
    i_rstn <= 1'b1;
    @(posedge i_clock);
    apb(1'b1, idx_drive, 8'h01);
    rd_chk(idx_drive, 8'h01, 1'b0);
    wrap_up();
  end
endmodule
bind ppc_port_config ppc_checker chk (.i_clock, .i_rstn, .i_apb, .o_pslverr, .i_expanded, .i_peripheral,
  .i_page_emul, .i_pwm, .i_serial, .i_interic, .i_can_tx, .o_pin_mode, .o_pin_page, .o_pin_pulse, .o_pin_serial,
  .o_pin_interic, .o_can, .o_wake_pull, .o_wake_low_drive, .o_analog_ctl);
